// *** hw/async_timer_pkg.sv ***
package async_timer_pkg;

  // apb register map, byte addresses
  localparam logic [7:0] REG_COUNTER = 8'h00;
  localparam logic [7:0] REG_COMPARE = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_IRQ_FLAGS = 8'h14;

  // holding channels, index equals the busy bit position in async_status
  localparam int CH_CONTROL = 0;
  localparam int CH_COMPARE = 1;
  localparam int CH_COUNTER = 2;
  localparam int NUM_CH = 3;

  // async_status fields
  localparam int STATUS_SELECT_BIT = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // irq mask and flag positions
  localparam int COMPARE_BIT = 4;
  localparam int OVERFLOW_BIT = 2;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAGS_IMPL = 8'h14;

  // timer_control fields
  localparam int CTRL_OUT_MODE_LSB = 4;
  localparam int CTRL_CLK_SEL_LSB = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER_MAX = 8'hFF;

  // timing counts
  localparam logic [1:0] LOAD_EDGES = 2'h2;
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam logic [2:0] WAKE_STALL_CYCLES = 3'h4;

  typedef enum logic [2:0]
  {
    SLEEP_NONE,
    SLEEP_IDLE,
    SLEEP_POWER_SAVE,
    SLEEP_POWER_DOWN,
    SLEEP_STANDBY,
    SLEEP_EXT_STANDBY
  } sleep_mode_t;

  typedef struct packed
  {
    logic [7:0] value;
    logic pending;
    logic [1:0] edges;
  } hold_t;

  typedef struct packed
  {
    logic compare;
    logic overflow;
  } timer_event_t;

endpackage : async_timer_pkg

// *** hw/async_timer_update_sync.sv ***
// Operation
// - select bit zero runs the timer on the bus clock, one on the crystal pin
// - async counter write sets counter busy; cleared when the counter loads
// - async compare write sets compare busy; cleared when compare loads
// - async control write sets control busy; cleared when control loads
// - counter reads give the timer value; compare and control read their holding register
// - async writes enter a holding register and load after two crystal rising edges
// - counter, compare and control each own a separate holding register
// - compare matching is off while a counter or compare write is pending
// - after a wake-up the interrupt logic rearms only after one crystal cycle
// - crystal oscillator runs in every sleep state except power-down and standby
// - wake-up starts on the timer clock cycle after the interrupt condition
// - after a timer wake-up the processor stalls four cycles
// - counter reads use a copy refreshed on every crystal rising edge
// - async flag sync takes three bus cycles plus one timer cycle; pin unsynchronised
// - each irq needs its enable bit, its flag and the global enable
// - flags set by events, cleared by vector acknowledge or writing one
`timescale 1ns/1ps
module async_timer_update_sync
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal pin
  input wire logic timer_crystal_in,
  // processor side
  input wire logic global_irq_enable,
  input wire logic compare_vector_ack,
  input wire logic overflow_vector_ack,
  input wire async_timer_pkg::sleep_mode_t sleep_state,
  // outputs
  output logic compare_irq,
  output logic overflow_irq,
  output logic compare_out,
  output logic wake_request,
  output logic cpu_stall,
  output logic osc_enable
);

  logic xtal_meta_reg;
  logic xtal_sync_reg;
  logic xtal_prev_reg;
  logic xtal_rise;
  logic async_clock_select;
  logic tick;
  logic running;
  logic [7:0] status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_flags_reg;
  logic [7:0] counter_value_reg;
  logic [7:0] counter_copy_reg;
  logic [7:0] compare_value_reg;
  logic [7:0] timer_control_reg;
  async_timer_pkg::hold_t hold_reg [async_timer_pkg::NUM_CH];
  logic [async_timer_pkg::NUM_CH-1:0] busy;
  logic [async_timer_pkg::NUM_CH-1:0] ch_write;
  logic [async_timer_pkg::NUM_CH-1:0] load_now;
  logic [7:0] load_val [async_timer_pkg::NUM_CH];
  async_timer_pkg::timer_event_t event_now;
  async_timer_pkg::timer_event_t flag_set;
  async_timer_pkg::timer_event_t sync_pipe_reg [async_timer_pkg::FLAG_SYNC_CYCLES-1];
  logic setup;
  logic wr_en;
  logic mapped;
  logic [7:0] rd_mux;
  logic [7:0] flag_clear;
  logic timer_sleep;
  logic wake_pending_reg;
  logic wake_armed_reg;
  logic [2:0] stall_count_reg;
  logic copy_due_reg;

  // crystal pin: two flops, then edge detect on the synchronised copy
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xtal_meta_reg <= 1'b0;
      xtal_sync_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end
    else
    begin
      xtal_meta_reg <= timer_crystal_in;
      xtal_sync_reg <= xtal_meta_reg;
      xtal_prev_reg <= xtal_sync_reg;
    end
  end

  assign xtal_rise = xtal_sync_reg && !xtal_prev_reg;
  assign async_clock_select = status_reg[async_timer_pkg::STATUS_SELECT_BIT];
  // the crystal rate is below a quarter of the bus clock, so no edge is missed
  assign tick = async_clock_select ? xtal_rise : 1'b1;
  assign running = timer_control_reg[async_timer_pkg::CTRL_CLK_SEL_LSB +: 3] != 3'h0;

  // apb decode: zero wait state, answer in the first access cycle
  assign setup = psel && !penable;
  assign mapped = (paddr == async_timer_pkg::REG_COUNTER) ||
                  (paddr == async_timer_pkg::REG_COMPARE) ||
                  (paddr == async_timer_pkg::REG_CONTROL) ||
                  (paddr == async_timer_pkg::REG_STATUS) ||
                  (paddr == async_timer_pkg::REG_IRQ_MASK) ||
                  (paddr == async_timer_pkg::REG_IRQ_FLAGS);
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign ch_write[async_timer_pkg::CH_COUNTER] = wr_en &&
    (paddr == async_timer_pkg::REG_COUNTER);
  assign ch_write[async_timer_pkg::CH_COMPARE] = wr_en &&
    (paddr == async_timer_pkg::REG_COMPARE);
  assign ch_write[async_timer_pkg::CH_CONTROL] = wr_en &&
    (paddr == async_timer_pkg::REG_CONTROL);

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (paddr)
      async_timer_pkg::REG_COUNTER: rd_mux = counter_copy_reg;
      async_timer_pkg::REG_COMPARE: rd_mux = hold_reg[async_timer_pkg::CH_COMPARE].value;
      async_timer_pkg::REG_CONTROL: rd_mux = hold_reg[async_timer_pkg::CH_CONTROL].value;
      async_timer_pkg::REG_STATUS: rd_mux = {status_reg[7:3], busy};
      async_timer_pkg::REG_IRQ_MASK: rd_mux = irq_mask_reg;
      async_timer_pkg::REG_IRQ_FLAGS: rd_mux = irq_flags_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup)
      begin
        prdata <= {24'h000000, rd_mux};
      end
    end
  end

  // select bit is software state; busy bits live in the channels
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_reg <= async_timer_pkg::STATUS_RESET;
    end
    else if (wr_en && paddr == async_timer_pkg::REG_STATUS)
    begin
      // only the select bit is writable; busy positions are dropped
      status_reg <= {4'h0, pwdata[3], 3'h0};
    end
  end

  // one holding register per destination, so channels never disturb each other
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < async_timer_pkg::NUM_CH; i++)
      begin
        hold_reg[i] <= '0;
      end
      hold_reg[async_timer_pkg::CH_CONTROL].value <= async_timer_pkg::CONTROL_RESET;
    end
    else
    begin
      for (int i = 0; i < async_timer_pkg::NUM_CH; i++)
      begin
        if (ch_write[i])
        begin
          // a rewrite while pending restarts the transfer with the new value
          hold_reg[i].value <= pwdata[7:0];
          hold_reg[i].pending <= async_clock_select;
          hold_reg[i].edges <= 2'h0;
        end
        else if (!async_clock_select)
        begin
          hold_reg[i].pending <= 1'b0;
        end
        else if (hold_reg[i].pending && xtal_rise)
        begin
          hold_reg[i].edges <= hold_reg[i].edges + 2'h1;
          if (hold_reg[i].edges == async_timer_pkg::LOAD_EDGES - 2'h1)
          begin
            hold_reg[i].pending <= 1'b0;
          end
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < async_timer_pkg::NUM_CH; g++)
    begin : g_chan
      assign busy[g] = hold_reg[g].pending;
      // second crystal edge after the write moves the value across
      assign load_now[g] = async_clock_select ?
        (hold_reg[g].pending && xtal_rise &&
         hold_reg[g].edges == async_timer_pkg::LOAD_EDGES - 2'h1) :
        ch_write[g];
      assign load_val[g] = async_clock_select ? hold_reg[g].value : pwdata[7:0];
    end
  endgenerate

  // timer-side destinations
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      compare_value_reg <= 8'h00;
      timer_control_reg <= async_timer_pkg::CONTROL_RESET;
    end
    else
    begin
      if (load_now[async_timer_pkg::CH_COMPARE])
      begin
        compare_value_reg <= load_val[async_timer_pkg::CH_COMPARE];
      end
      if (load_now[async_timer_pkg::CH_CONTROL])
      begin
        timer_control_reg <= load_val[async_timer_pkg::CH_CONTROL];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      counter_value_reg <= 8'h00;
    end
    else if (load_now[async_timer_pkg::CH_COUNTER])
    begin
      counter_value_reg <= load_val[async_timer_pkg::CH_COUNTER];
    end
    else if (tick && running)
    begin
      counter_value_reg <= counter_value_reg + 8'h01;
    end
  end

  // bus-side copy moves one cycle after a crystal edge, once that edge's load or count
  // has landed; it still reads stale right after wake-up until the next edge
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      copy_due_reg <= 1'b0;
      counter_copy_reg <= 8'h00;
    end
    else
    begin
      copy_due_reg <= xtal_rise;
      if (!async_clock_select || copy_due_reg)
      begin
        counter_copy_reg <= counter_value_reg;
      end
    end
  end

  // compare is masked while the counter or compare value is in flight
  assign event_now.compare = tick && running &&
    !busy[async_timer_pkg::CH_COUNTER] && !busy[async_timer_pkg::CH_COMPARE] &&
    !load_now[async_timer_pkg::CH_COUNTER] &&
    counter_value_reg == compare_value_reg;
  assign event_now.overflow = tick && running &&
    counter_value_reg == async_timer_pkg::COUNTER_MAX;

  // compare pin follows the timer tick directly, with no bus-clock resync
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      compare_out <= 1'b0;
    end
    else if (event_now.compare)
    begin
      unique case (timer_control_reg[async_timer_pkg::CTRL_OUT_MODE_LSB +: 2])
        2'h0: compare_out <= compare_out;
        2'h1: compare_out <= !compare_out;
        2'h2: compare_out <= 1'b0;
        2'h3: compare_out <= 1'b1;
      endcase
    end
  end

  // flag crossing: the tick plus a short pipe gives three bus cycles of latency
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < async_timer_pkg::FLAG_SYNC_CYCLES - 1; i++)
      begin
        sync_pipe_reg[i] <= '0;
      end
    end
    else
    begin
      sync_pipe_reg[0] <= event_now;
      for (int i = 1; i < async_timer_pkg::FLAG_SYNC_CYCLES - 1; i++)
      begin
        sync_pipe_reg[i] <= sync_pipe_reg[i-1];
      end
    end
  end

  assign flag_set = async_clock_select ?
    sync_pipe_reg[async_timer_pkg::FLAG_SYNC_CYCLES-2] : event_now;

  always_comb
  begin
    flag_clear = 8'h00;
    if (wr_en && paddr == async_timer_pkg::REG_IRQ_FLAGS)
    begin
      flag_clear = pwdata[7:0] & async_timer_pkg::FLAGS_IMPL;
    end
    flag_clear[async_timer_pkg::COMPARE_BIT] = flag_clear[async_timer_pkg::COMPARE_BIT] ||
      compare_vector_ack;
    flag_clear[async_timer_pkg::OVERFLOW_BIT] = flag_clear[async_timer_pkg::OVERFLOW_BIT] ||
      overflow_vector_ack;
  end

  // a set in the same cycle as a clear wins
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_flags_reg <= async_timer_pkg::FLAGS_RESET;
    end
    else
    begin
      irq_flags_reg <= irq_flags_reg & ~flag_clear;
      if (flag_set.compare)
      begin
        irq_flags_reg[async_timer_pkg::COMPARE_BIT] <= 1'b1;
      end
      if (flag_set.overflow)
      begin
        irq_flags_reg[async_timer_pkg::OVERFLOW_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_mask_reg <= async_timer_pkg::MASK_RESET;
    end
    else if (wr_en && paddr == async_timer_pkg::REG_IRQ_MASK)
    begin
      irq_mask_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      compare_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end
    else
    begin
      compare_irq <= global_irq_enable && irq_mask_reg[async_timer_pkg::COMPARE_BIT] &&
        irq_flags_reg[async_timer_pkg::COMPARE_BIT];
      overflow_irq <= global_irq_enable && irq_mask_reg[async_timer_pkg::OVERFLOW_BIT] &&
        irq_flags_reg[async_timer_pkg::OVERFLOW_BIT];
    end
  end

  // sleep and wake-up
  assign timer_sleep = sleep_state == async_timer_pkg::SLEEP_POWER_SAVE ||
    sleep_state == async_timer_pkg::SLEEP_EXT_STANDBY;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_enable <= 1'b0;
    end
    else
    begin
      osc_enable <= async_clock_select &&
        sleep_state != async_timer_pkg::SLEEP_POWER_DOWN &&
        sleep_state != async_timer_pkg::SLEEP_STANDBY;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_pending_reg <= 1'b0;
      wake_armed_reg <= 1'b1;
      wake_request <= 1'b0;
    end
    else
    begin
      wake_request <= 1'b0;
      if (wake_pending_reg && tick)
      begin
        // wake begins on the timer cycle after the condition
        wake_pending_reg <= 1'b0;
        wake_request <= 1'b1;
        wake_armed_reg <= 1'b0;
      end
      else if (timer_sleep && wake_armed_reg &&
               ((event_now.compare && irq_mask_reg[async_timer_pkg::COMPARE_BIT]) ||
                (event_now.overflow && irq_mask_reg[async_timer_pkg::OVERFLOW_BIT])))
      begin
        wake_pending_reg <= 1'b1;
      end
      else if (!wake_armed_reg && tick)
      begin
        // a timer event up to and including this tick cannot wake a sleep; later events can
        wake_armed_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stall_count_reg <= 3'h0;
      cpu_stall <= 1'b0;
    end
    else if (wake_request)
    begin
      stall_count_reg <= async_timer_pkg::WAKE_STALL_CYCLES - 3'h1;
      cpu_stall <= 1'b1;
    end
    else if (stall_count_reg != 3'h0)
    begin
      stall_count_reg <= stall_count_reg - 3'h1;
    end
    else
    begin
      cpu_stall <= 1'b0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  AST_COUNTER_BUSY_SET: assert property ((ch_write[2] && async_clock_select) |=> busy[2])
    else $error("counter write did not set busy");
  AST_COMPARE_BUSY_CLEAR: assert property ($fell(busy[1]) && async_clock_select |->
    $past(xtal_rise) && compare_value_reg == hold_reg[1].value)
    else $error("compare busy fell without a load");
  AST_CONTROL_BUSY_SET: assert property ((ch_write[0] && async_clock_select) |=> busy[0])
    else $error("control write did not set busy");
  AST_TWO_EDGES: assert property ((ch_write[1] && async_clock_select) |=>
    busy[1] until_with (xtal_rise && hold_reg[1].edges == 2'h1))
    else $error("compare loaded before two crystal edges");
  AST_NO_MATCH_BUSY: assert property ((busy[2] || busy[1]) |=> $stable(compare_out))
    else $error("compare match while write pending");
  AST_FLAG_SYNC: assert property ((event_now.compare && async_clock_select) |->
    ##3 irq_flags_reg[4])
    else $error("compare flag not set three cycles after tick");
  AST_STALL_FOUR: assert property (wake_request |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("stall not four cycles");
  AST_OSC_OFF: assert property ((sleep_state == async_timer_pkg::SLEEP_POWER_DOWN) |=>
    !osc_enable)
    else $error("oscillator running in power-down");
  AST_IRQ_GATE: assert property (compare_irq |-> $past(global_irq_enable) &&
    $past(irq_mask_reg[4]) && $past(irq_flags_reg[4]))
    else $error("compare irq without enable and flag");
  AST_BUSY_RO: assert property ((wr_en && paddr == 8'h0C && busy == 3'h0) |=> busy == 3'h0)
    else $error("software set a busy bit");

  COV_ASYNC_LOAD: cover property (ch_write[2] && async_clock_select ##[1:40] $fell(busy[2]));
  COV_FLAG_SET: cover property (flag_set.overflow);
  COV_WAKE: cover property (wake_request ##5 !cpu_stall);
  COV_SET_CLEAR: cover property (flag_set.compare && compare_vector_ack);

endmodule : async_timer_update_sync

// *** testbench/crystal_model.sv ***
`timescale 1ns/1ps
module crystal_model
#(
  // 146 ns period keeps the bus clock well above four times the crystal rate
  parameter int HALF_NS = 73
)
(
  // oscillator control
  input wire logic osc_enable,
  // crystal pin
  output logic crystal_out
);
  initial
  begin
    crystal_out = 1'b0;
  end

  // the pin stands still while the oscillator is stopped, as a real crystal would
  always
  begin
    #HALF_NS;
    if (osc_enable)
    begin
      crystal_out = ~crystal_out;
    end
  end
endmodule : crystal_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_crystal_in;
  logic global_irq_enable = 1'b1;
  logic compare_vector_ack = 1'b0;
  logic overflow_vector_ack = 1'b0;
  async_timer_pkg::sleep_mode_t sleep_state = async_timer_pkg::SLEEP_NONE;
  logic compare_irq;
  logic overflow_irq;
  logic osc_enable;
  logic compare_out;
  logic wake_request;
  logic cpu_stall;
  int k;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int check_count = 0;

  always #5 clock = ~clock;

  async_timer_update_sync dut_u
  (
    .clock(clock),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timer_crystal_in(timer_crystal_in),
    .global_irq_enable(global_irq_enable),
    .compare_vector_ack(compare_vector_ack),
    .overflow_vector_ack(overflow_vector_ack),
    .sleep_state(sleep_state),
    .compare_irq(compare_irq),
    .overflow_irq(overflow_irq),
    .compare_out(compare_out),
    .wake_request(wake_request),
    .cpu_stall(cpu_stall),
    .osc_enable(osc_enable)
  );

  crystal_model xtal_u
  (
    .osc_enable(osc_enable),
    .crystal_out(timer_crystal_in)
  );

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic give_up();
    n_mismatch++;
    wrap_up();
  endtask : give_up

  // one apb transfer; read data and error are taken at the pready edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && i < 20)
    begin
      @(posedge clock);
      i++;
    end
    if (pready !== 1'b1)
      give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll status until the given busy bits are all low
  task automatic wait_clear(input logic [7:0] m);
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(1'b0, async_timer_pkg::REG_STATUS, 32'h0);
      if ((rd[7:0] & m) === 8'h00)
        break;
    end
    if (i == 100)
      give_up();
  endtask : wait_clear

  // poll the flag register until one of the given flags is set
  task automatic wait_flag(input logic [7:0] m);
    int i;
    for (i = 0; i < 2000; i++)
    begin
      apb(1'b0, async_timer_pkg::REG_IRQ_FLAGS, 32'h0);
      if ((rd[7:0] & m) !== 8'h00)
        break;
    end
    if (i == 2000)
      give_up();
  endtask : wait_flag

  initial
  begin
    #900000;
    give_up();
  end

  initial
  begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, async_timer_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, async_timer_pkg::REG_IRQ_MASK, 32'h0);
    chk(rd, 32'h0000_0000);
    // synchronous mode: no busy bit, compare reads back its holding value
    apb(1'b1, async_timer_pkg::REG_COMPARE, 32'h0000_0033);
    apb(1'b0, async_timer_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, async_timer_pkg::REG_COMPARE, 32'h0);
    chk(rd, 32'h0000_0033);
    apb(1'b1, async_timer_pkg::REG_IRQ_MASK, 32'h0000_0014);
    apb(1'b0, async_timer_pkg::REG_IRQ_MASK, 32'h0);
    chk(rd, 32'h0000_0014);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // timer irqs off before the clock source changes
    apb(1'b1, async_timer_pkg::REG_IRQ_MASK, 32'h0000_0000);
    // busy bits ignore the write, select bit takes it
    apb(1'b1, async_timer_pkg::REG_STATUS, 32'h0000_000F);
    apb(1'b0, async_timer_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0008);
    chk({31'h0, osc_enable}, 32'h0000_0001);
    // two channels in flight together; every destination is rewritten after the switch
    apb(1'b1, async_timer_pkg::REG_COMPARE, 32'h0000_0080);
    apb(1'b1, async_timer_pkg::REG_COUNTER, 32'h0000_00FD);
    apb(1'b0, async_timer_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0000_000E);
    apb(1'b0, async_timer_pkg::REG_COMPARE, 32'h0);
    chk(rd, 32'h0000_0080);
    apb(1'b0, async_timer_pkg::REG_COUNTER, 32'h0);
    chk(rd, 32'h0000_0000);
    wait_clear(8'h06);
    apb(1'b0, async_timer_pkg::REG_COUNTER, 32'h0);
    chk(rd, 32'h0000_00FD);
    apb(1'b1, async_timer_pkg::REG_CONTROL, 32'h0000_0001);
    apb(1'b0, async_timer_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(1'b0, async_timer_pkg::REG_CONTROL, 32'h0);
    chk(rd, 32'h0000_0001);
    wait_clear(8'h01);
    apb(1'b1, async_timer_pkg::REG_IRQ_FLAGS, 32'h0000_0014);
    apb(1'b1, async_timer_pkg::REG_IRQ_MASK, 32'h0000_0014);
    // counter runs through 0xFF into overflow
    wait_flag(8'h04);
    repeat (2) @(posedge clock);
    chk({31'h0, overflow_irq}, 32'h0000_0001);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clock);
    chk({31'h0, overflow_irq}, 32'h0000_0000);
    // overflow flag cleared by its vector acknowledge
    overflow_vector_ack <= 1'b1;
    global_irq_enable <= 1'b1;
    @(posedge clock);
    overflow_vector_ack <= 1'b0;
    repeat (2) @(posedge clock);
    apb(1'b0, async_timer_pkg::REG_IRQ_FLAGS, 32'h0);
    chk(rd & 32'h0000_0004, 32'h0000_0000);
    // compare match at 0x80, cleared by writing one
    wait_flag(8'h10);
    repeat (2) @(posedge clock);
    chk({31'h0, compare_irq}, 32'h0000_0001);
    apb(1'b1, async_timer_pkg::REG_IRQ_FLAGS, 32'h0000_0010);
    apb(1'b0, async_timer_pkg::REG_IRQ_FLAGS, 32'h0);
    chk(rd, 32'h0000_0000);
    // pin held through the first match, then toggles on the next one
    apb(1'b1, async_timer_pkg::REG_CONTROL, 32'h0000_0011);
    wait_clear(8'h01);
    chk({31'h0, compare_out}, 32'h0000_0000);
    apb(1'b0, async_timer_pkg::REG_COUNTER, 32'h0);
    apb(1'b1, async_timer_pkg::REG_COMPARE, {24'h000000, rd[7:0] + 8'h08});
    wait_clear(8'h02);
    wait_flag(8'h10);
    chk({31'h0, compare_out}, 32'h0000_0001);
    compare_vector_ack <= 1'b1;
    @(posedge clock);
    compare_vector_ack <= 1'b0;
    repeat (2) @(posedge clock);
    apb(1'b0, async_timer_pkg::REG_IRQ_FLAGS, 32'h0);
    chk(rd & 32'h0000_0010, 32'h0000_0000);
    // timer wake-up from power-save; write and wait first so the compare match is no longer masked by compare busy
    apb(1'b0, async_timer_pkg::REG_COUNTER, 32'h0);
    apb(1'b1, async_timer_pkg::REG_COMPARE, {24'h000000, rd[7:0] + 8'h08});
    wait_clear(8'h02);
    sleep_state <= async_timer_pkg::SLEEP_POWER_SAVE;
    for (k = 0; k < 1000 && wake_request !== 1'b1; k++)
    begin
      @(posedge clock);
    end
    if (wake_request !== 1'b1)
      give_up();
    chk({31'h0, wake_request}, 32'h0000_0001);
    sleep_state <= async_timer_pkg::SLEEP_NONE;
    repeat (4) @(posedge clock);
    chk({31'h0, cpu_stall}, 32'h0000_0001);
    @(posedge clock);
    chk({31'h0, cpu_stall}, 32'h0000_0000);
    // no timer access follows the power-down: its contents count as lost
    sleep_state <= async_timer_pkg::SLEEP_POWER_DOWN;
    repeat (3) @(posedge clock);
    chk({31'h0, osc_enable}, 32'h0000_0000);
    sleep_state <= async_timer_pkg::SLEEP_IDLE;
    repeat (3) @(posedge clock);
    chk({31'h0, osc_enable}, 32'h0000_0001);
    wrap_up();
  end
endmodule : tb
